// *** core/cae_alert_top.sv ***
// module: charger alert enable logic with register port and alert output
//
// Operation
// - input current above threshold raises alert
// - battery current below threshold raises alert
// - die temperature above threshold raises alert
// - series resistance above threshold raises alert
// - thermistor reading above high threshold alerts
// - thermistor reading below low threshold alerts
// - charger state enables at 0x0E, reset zero
// - detection failure raises alert when enabled
// - detection entry raises alert when enabled
// - absorb phase start raises alert when enabled
// - charger suspend raises alert when enabled
// - regulated charge onset raises alert when enabled
// - thermal pause raises alert when enabled
// - flags readable, host clears by writing them
// - thresholds held as signed 16-bit values
`timescale 1ns/1ps
module cae_alert_top (
   input  wire logic                     core_clk,
   input  wire logic                     reset_n,
   input  wire logic [cae_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cae_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic      [cae_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic signed [15:0]       input_current,
   input  wire logic signed [15:0]       battery_current,
   input  wire logic signed [15:0]       die_temp,
   input  wire logic signed [15:0]       series_resistance,
   input  wire logic signed [15:0]       ntc_reading,
   input  wire logic                     detect_failed_event,
   input  wire logic                     detect_entry_event,
   input  wire logic                     absorb_start_event,
   input  wire logic                     suspended_event,
   input  wire logic                     regulated_charge_phase,
   input  wire logic                     thermal_pause_event,
   output logic                          smb_alert_n
);
   import cae_pkg::*;

   // =====================================================
   // registers
   logic signed [15:0] input_current_high_threshold;
   logic signed [15:0] battery_current_low_threshold;
   logic signed [15:0] junction_hot_threshold;
   logic signed [15:0] series_resistance_high_threshold;
   logic signed [15:0] ntc_high_threshold;
   logic signed [15:0] ntc_low_threshold;
   logic [15:0]        limit_en_reg;
   logic [12:0]        charger_state_notify_enables;
   logic [15:0]        reg_rdata_next;
   logic               alert_reg;

   // =====================================================
   // decode
   wire wr_iin   = reg_write && (reg_addr == ADDR_IIN_HI_LIM);
   wire wr_ibat  = reg_write && (reg_addr == ADDR_IBAT_LO_LIM);
   wire wr_die   = reg_write && (reg_addr == ADDR_DIE_HI_LIM);
   wire wr_bsr   = reg_write && (reg_addr == ADDR_BSR_HI_LIM);
   wire wr_ntchi = reg_write && (reg_addr == ADDR_NTC_HI_LIM);
   wire wr_ntclo = reg_write && (reg_addr == ADDR_NTC_LO_LIM);
   wire wr_lim   = reg_write && (reg_addr == ADDR_LIMIT_EN);
   wire wr_chg   = reg_write && (reg_addr == ADDR_CHG_EN);
   wire wr_lflag = reg_write && (reg_addr == ADDR_LIMIT_FLAGS);
   wire wr_cflag = reg_write && (reg_addr == ADDR_CHG_FLAGS);

   // =====================================================
   // writable registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         input_current_high_threshold     <= LIMIT_RESET;
         battery_current_low_threshold    <= LIMIT_RESET;
         junction_hot_threshold           <= LIMIT_RESET;
         series_resistance_high_threshold <= LIMIT_RESET;
         ntc_high_threshold               <= LIMIT_RESET;
         ntc_low_threshold                <= LIMIT_RESET;
         limit_en_reg                     <= LIMIT_RESET;
         charger_state_notify_enables     <= CHG_EN_RESET;
      end else begin
         if (wr_iin)   input_current_high_threshold     <= reg_wdata;
         if (wr_ibat)  battery_current_low_threshold    <= reg_wdata;
         if (wr_die)   junction_hot_threshold           <= reg_wdata;
         if (wr_bsr)   series_resistance_high_threshold <= reg_wdata;
         if (wr_ntchi) ntc_high_threshold               <= reg_wdata;
         if (wr_ntclo) ntc_low_threshold                <= reg_wdata;
         if (wr_lim)   limit_en_reg                     <= reg_wdata;
         if (wr_chg)   charger_state_notify_enables     <= reg_wdata[NCHG-1:0];
      end
   end

   // =====================================================
   // enable fields
   wire input_current_high_enable     = limit_en_reg[BIT_IIN_HI];
   wire battery_current_low_enable    = limit_en_reg[BIT_IBAT_LO];
   wire junction_hot_enable           = limit_en_reg[BIT_DIE_HI];
   wire series_resistance_high_enable = limit_en_reg[BIT_BSR_HI];
   wire ntc_reading_high_enable       = limit_en_reg[BIT_NTC_HI];
   wire ntc_reading_low_enable        = limit_en_reg[BIT_NTC_LO];
   wire regulated_charge_enable       = charger_state_notify_enables[BIT_REG_CHARGE];

   wire [NLIM-1:0] lim_enable = {input_current_high_enable, battery_current_low_enable,
                                 junction_hot_enable, series_resistance_high_enable,
                                 ntc_reading_high_enable, ntc_reading_low_enable};

   // =====================================================
   // limit comparators and flags
   wire [NLIM-1:0] limit_hit;
   wire [NLIM-1:0] limit_flags;
   wire            limit_any;

   cae_limit_cmp u_cmp (
      .input_current                    (input_current),
      .battery_current                  (battery_current),
      .die_temp                         (die_temp),
      .series_resistance                (series_resistance),
      .ntc_reading                      (ntc_reading),
      .input_current_high_threshold     (input_current_high_threshold),
      .battery_current_low_threshold    (battery_current_low_threshold),
      .junction_hot_threshold           (junction_hot_threshold),
      .series_resistance_high_threshold (series_resistance_high_threshold),
      .ntc_high_threshold               (ntc_high_threshold),
      .ntc_low_threshold                (ntc_low_threshold),
      .limit_hit                        (limit_hit)
   );

   cae_flag_bank #(.N(NLIM)) u_lim_flags (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .event_in   (limit_hit),
      .enable     (lim_enable),
      .clear_we   (wr_lflag),
      .clear_bits (reg_wdata[NLIM-1:0]),
      .flag_reg   (limit_flags),
      .any_alert  (limit_any)
   );

   // =====================================================
   // charger state events, synchronised
   logic [NCHG-1:0] chg_meta_reg;
   logic [NCHG-1:0] chg_sync_reg;
   logic [NCHG-1:0] chg_raw;
   always_comb begin
      chg_raw                  = '0;
      chg_raw[BIT_DETECT_FAIL] = detect_failed_event;
      chg_raw[BIT_DETECT]      = detect_entry_event;
      chg_raw[BIT_ABSORB]      = absorb_start_event;
      chg_raw[BIT_SUSPENDED]   = suspended_event;
      chg_raw[BIT_REG_CHARGE]  = regulated_charge_phase;
      chg_raw[BIT_NTC_PAUSE]   = thermal_pause_event;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         chg_meta_reg <= '0;
         chg_sync_reg <= '0;
      end else begin
         chg_meta_reg <= chg_raw;
         chg_sync_reg <= chg_meta_reg;
      end
   end

   wire [NCHG-1:0] chg_flags;
   wire            chg_any;
   wire [NCHG-1:0] chg_enable = charger_state_notify_enables & CHG_MASK;

   cae_flag_bank #(.N(NCHG)) u_chg_flags (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .event_in   (chg_sync_reg),
      .enable     (chg_enable),
      .clear_we   (wr_cflag),
      .clear_bits (reg_wdata[NCHG-1:0]),
      .flag_reg   (chg_flags),
      .any_alert  (chg_any)
   );

   // =====================================================
   // alert output, active low
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= limit_any | chg_any;
      end
   end
   assign smb_alert_n = ~alert_reg;

   // =====================================================
   // read path
   always_comb begin
      case (reg_addr)
         ADDR_IIN_HI_LIM:  reg_rdata_next = input_current_high_threshold;
         ADDR_IBAT_LO_LIM: reg_rdata_next = battery_current_low_threshold;
         ADDR_DIE_HI_LIM:  reg_rdata_next = junction_hot_threshold;
         ADDR_BSR_HI_LIM:  reg_rdata_next = series_resistance_high_threshold;
         ADDR_NTC_HI_LIM:  reg_rdata_next = ntc_high_threshold;
         ADDR_NTC_LO_LIM:  reg_rdata_next = ntc_low_threshold;
         ADDR_LIMIT_EN:    reg_rdata_next = limit_en_reg;
         ADDR_CHG_EN:      reg_rdata_next = {3'b000, charger_state_notify_enables};
         ADDR_LIMIT_FLAGS: reg_rdata_next = {10'b00_0000_0000, limit_flags};
         ADDR_CHG_FLAGS:   reg_rdata_next = {3'b000, chg_flags};
         default:          reg_rdata_next = READ_ZERO;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= READ_ZERO;
      end else if (reg_read) begin
         reg_rdata <= reg_rdata_next;
      end else begin
         reg_rdata <= READ_ZERO;
      end
   end

   // =====================================================
   // checks
   a_iin_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (input_current_high_enable && limit_hit[BIT_IIN_HI]) |=> limit_flags[BIT_IIN_HI])
      else $error("input current flag not set");
   a_ibat_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (battery_current_low_enable && limit_hit[BIT_IBAT_LO]) |=> limit_flags[BIT_IBAT_LO])
      else $error("battery current flag not set");
   a_die_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (junction_hot_enable && die_temp > junction_hot_threshold) |=> limit_flags[BIT_DIE_HI])
      else $error("die flag not set");
   a_ntc_lo_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ntc_reading_low_enable && ntc_reading < ntc_low_threshold) |=> limit_flags[BIT_NTC_LO])
      else $error("thermistor low flag not set");
   a_chg_en_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_chg |=> charger_state_notify_enables == $past(reg_wdata[NCHG-1:0]))
      else $error("charger enable write lost");
   sequence s_detect_seen;
      chg_enable[BIT_DETECT] && detect_entry_event ##2 chg_enable[BIT_DETECT]
         ##1 chg_enable[BIT_DETECT];
   endsequence
   a_detect_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_detect_seen |-> chg_flags[BIT_DETECT] ##1 !smb_alert_n)
      else $error("detection alert missing");
   a_alert_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
      (|(limit_flags & lim_enable)) |=> !smb_alert_n)
      else $error("alert not asserted");
   a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!(|(limit_flags & lim_enable)) && !(|(chg_flags & chg_enable))) |=> smb_alert_n)
      else $error("alert without enabled flag");
   a_flag_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_lflag && reg_wdata[BIT_BSR_HI] && !limit_hit[BIT_BSR_HI]) |=> !limit_flags[BIT_BSR_HI])
      else $error("flag not cleared");
   a_read_data: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == ADDR_NTC_HI_LIM) |=> reg_rdata == $past(ntc_high_threshold))
      else $error("threshold readback wrong");

   // =====================================================
   // further checks
   a_bsr_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (series_resistance_high_enable && limit_hit[BIT_BSR_HI]) |=> limit_flags[BIT_BSR_HI])
      else $error("resistance flag not set");
   a_ntc_hi_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ntc_reading_high_enable && ntc_reading > ntc_high_threshold) |=> limit_flags[BIT_NTC_HI])
      else $error("thermistor high flag not set");
   sequence s_fail_seen;
      chg_enable[BIT_DETECT_FAIL] && detect_failed_event ##2 chg_enable[BIT_DETECT_FAIL];
   endsequence
   a_fail_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_fail_seen |=> chg_flags[BIT_DETECT_FAIL])
      else $error("detection failure flag missing");
   a_absorb_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      (chg_enable[BIT_ABSORB] && chg_sync_reg[BIT_ABSORB]) |=> chg_flags[BIT_ABSORB])
      else $error("absorb flag not set");
   sequence s_suspend_seen;
      chg_enable[BIT_SUSPENDED] && suspended_event ##2 chg_enable[BIT_SUSPENDED]
         ##1 chg_enable[BIT_SUSPENDED];
   endsequence
   a_suspend_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_suspend_seen |-> chg_flags[BIT_SUSPENDED] ##1 !smb_alert_n)
      else $error("suspend alert missing");
   a_charge_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      (regulated_charge_enable && chg_sync_reg[BIT_REG_CHARGE]) |=> chg_flags[BIT_REG_CHARGE])
      else $error("charge phase flag not set");
   a_charge_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!regulated_charge_enable && !chg_flags[BIT_REG_CHARGE]) |=> !chg_flags[BIT_REG_CHARGE])
      else $error("charge phase flag set while disabled");
   a_pause_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
      (chg_enable[BIT_NTC_PAUSE] && chg_sync_reg[BIT_NTC_PAUSE]) |=> chg_flags[BIT_NTC_PAUSE])
      else $error("pause flag not set");
   a_chg_en_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      (reg_read && reg_addr == ADDR_CHG_EN)
         |=> reg_rdata == {3'b000, $past(charger_state_notify_enables)})
      else $error("charger enable readback wrong");
   a_chg_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_cflag && reg_wdata[BIT_ABSORB] && !chg_sync_reg[BIT_ABSORB]) |=> !chg_flags[BIT_ABSORB])
      else $error("charger flag not cleared");
   a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      (limit_flags[BIT_IIN_HI] && !(wr_lflag && reg_wdata[BIT_IIN_HI]))
         |=> limit_flags[BIT_IIN_HI])
      else $error("flag lost without clear");
   a_alert_chg: assert property (@(posedge core_clk) disable iff (!reset_n)
      (|(chg_flags & chg_enable)) |=> !smb_alert_n)
      else $error("charger alert not asserted");
   a_thr_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_die |=> junction_hot_threshold == $past(reg_wdata))
      else $error("threshold write lost");
endmodule // cae_alert_top

// *** core/cae_flag_bank.sv ***
// module: sticky flag bank, set wins over write-one-to-clear
`timescale 1ns/1ps
module cae_flag_bank #(
   parameter int N = 6
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic [N-1:0] event_in,
   input  wire logic [N-1:0] enable,
   input  wire logic         clear_we,
   input  wire logic [N-1:0] clear_bits,
   output logic      [N-1:0] flag_reg,
   output wire logic         any_alert
);
   import cae_pkg::*;
   logic [N-1:0] flag_next;
   // =====================================================
   // per bit set and clear
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_flag
         assign flag_next[i] = (enable[i] & event_in[i]) |
                               (flag_reg[i] & ~(clear_we & clear_bits[i]));
      end
   endgenerate
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end
   assign any_alert = |(flag_reg & enable);
endmodule // cae_flag_bank

// *** core/cae_limit_cmp.sv ***
// module: signed threshold comparators for the six limit alerts
`timescale 1ns/1ps
module cae_limit_cmp (
   input  wire logic signed [15:0] input_current,
   input  wire logic signed [15:0] battery_current,
   input  wire logic signed [15:0] die_temp,
   input  wire logic signed [15:0] series_resistance,
   input  wire logic signed [15:0] ntc_reading,
   input  wire logic signed [15:0] input_current_high_threshold,
   input  wire logic signed [15:0] battery_current_low_threshold,
   input  wire logic signed [15:0] junction_hot_threshold,
   input  wire logic signed [15:0] series_resistance_high_threshold,
   input  wire logic signed [15:0] ntc_high_threshold,
   input  wire logic signed [15:0] ntc_low_threshold,
   output wire logic [5:0]         limit_hit
);
   import cae_pkg::*;
   // =====================================================
   // comparisons
   assign limit_hit[BIT_IIN_HI]  = input_current > input_current_high_threshold;
   assign limit_hit[BIT_IBAT_LO] = battery_current < battery_current_low_threshold;
   assign limit_hit[BIT_DIE_HI]  = die_temp > junction_hot_threshold;
   assign limit_hit[BIT_BSR_HI]  = series_resistance > series_resistance_high_threshold;
   assign limit_hit[BIT_NTC_HI]  = ntc_reading > ntc_high_threshold;
   assign limit_hit[BIT_NTC_LO]  = ntc_reading < ntc_low_threshold;
endmodule // cae_limit_cmp

// *** core/cae_pkg.sv ***
// package: register map, field positions and sizes for the alert enable logic
package cae_pkg;
   // =====================================================
   // sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NLIM   = 6;
   localparam int NCHG   = 13;
   // =====================================================
   // command codes
   localparam logic [7:0] ADDR_IIN_HI_LIM   = 8'h01;
   localparam logic [7:0] ADDR_IBAT_LO_LIM  = 8'h02;
   localparam logic [7:0] ADDR_DIE_HI_LIM   = 8'h03;
   localparam logic [7:0] ADDR_BSR_HI_LIM   = 8'h04;
   localparam logic [7:0] ADDR_NTC_HI_LIM   = 8'h05;
   localparam logic [7:0] ADDR_NTC_LO_LIM   = 8'h06;
   localparam logic [7:0] ADDR_LIMIT_EN     = 8'h0D;
   localparam logic [7:0] ADDR_CHG_EN       = 8'h0E;
   localparam logic [7:0] ADDR_LIMIT_FLAGS  = 8'h10;
   localparam logic [7:0] ADDR_CHG_FLAGS    = 8'h11;
   // =====================================================
   // limit alert bit positions
   localparam int BIT_NTC_LO   = 0;
   localparam int BIT_NTC_HI   = 1;
   localparam int BIT_BSR_HI   = 2;
   localparam int BIT_DIE_HI   = 3;
   localparam int BIT_IBAT_LO  = 4;
   localparam int BIT_IIN_HI   = 5;
   // charger state bit positions
   localparam int BIT_NTC_PAUSE  = 5;
   localparam int BIT_REG_CHARGE = 6;
   localparam int BIT_SUSPENDED  = 8;
   localparam int BIT_ABSORB     = 9;
   localparam int BIT_DETECT     = 11;
   localparam int BIT_DETECT_FAIL = 12;
   // =====================================================
   // reset values and charger enable mask
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [12:0] CHG_EN_RESET = 13'h0000;
   localparam logic [12:0] CHG_MASK    = 13'h1B60;
   localparam logic [15:0] READ_ZERO   = 16'h0000;
endpackage

// *** tb/cae_alert_top_test.sv ***
// testbench: register access, limit and charger alerts, clearing
`timescale 1ns/1ps
module cae_alert_top_test;
   import cae_pkg::*;
   logic               core_clk = 1'b0;
   logic               reset_n  = 1'b0;
   logic [7:0]         reg_addr = 8'h00;
   logic [15:0]        reg_wdata = 16'h0000;
   logic               reg_write = 1'b0;
   logic               reg_read  = 1'b0;
   logic [15:0]        reg_rdata;
   logic signed [15:0] input_current, battery_current, die_temp, series_resistance, ntc_reading;
   logic               detect_failed_event, detect_entry_event, absorb_start_event;
   logic               suspended_event, regulated_charge_phase, thermal_pause_event;
   logic               smb_alert_n;
   int                 failures  = 0;
   int                 tests_run = 0;
   int                 cycles    = 0;
   int                 tel_of [6] = '{4, 4, 3, 2, 1, 0};
   logic [15:0]        trip [6] = '{16'hFF38, 16'h00C8, 16'h00C8, 16'h00C8, 16'hFF38, 16'h00C8};
   logic [15:0]        thr [6] = '{16'h0064, 16'hFF9C, 16'h0064, 16'h0064, 16'h0064, 16'hFF9C};
   int                 chg_bit [6] = '{12, 11, 9, 8, 6, 5};

   always #4 core_clk = ~core_clk;

   cae_alert_top cae_alert_top_i (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .input_current(input_current), .battery_current(battery_current), .die_temp(die_temp),
      .series_resistance(series_resistance), .ntc_reading(ntc_reading),
      .detect_failed_event(detect_failed_event), .detect_entry_event(detect_entry_event),
      .absorb_start_event(absorb_start_event), .suspended_event(suspended_event),
      .regulated_charge_phase(regulated_charge_phase),
      .thermal_pause_event(thermal_pause_event), .smb_alert_n(smb_alert_n)
   );

   cae_charger_model cae_charger_model_i (
      .core_clk(core_clk), .input_current(input_current), .battery_current(battery_current),
      .die_temp(die_temp), .series_resistance(series_resistance), .ntc_reading(ntc_reading),
      .detect_failed_event(detect_failed_event), .detect_entry_event(detect_entry_event),
      .absorb_start_event(absorb_start_event), .suspended_event(suspended_event),
      .regulated_charge_phase(regulated_charge_phase),
      .thermal_pause_event(thermal_pause_event)
   );

   // =====================================================
   // compare and report
   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk_alert(input logic e);
      tests_run++;
      if (smb_alert_n !== e) begin
         failures++;
         $display("wrong value smb_alert_n expected %b seen %b", e, smb_alert_n);
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // =====================================================
   // register port
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk_word(nm, e, reg_rdata);
   endtask

   // flag and alert latency is at most four cycles
   task automatic settle();
      repeat (6) @(posedge core_clk);
      #1;
   endtask

   // =====================================================
   // timeout
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         summarize();
      end
   end

   // =====================================================
   // tests
   initial begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      chk_alert(1'b1);
      reg_rd_chk(ADDR_CHG_EN, 16'h0000, "chg_en reset");
      reg_wr(ADDR_CHG_EN, 16'hFFFF);
      reg_rd_chk(ADDR_CHG_EN, 16'h1FFF, "chg_en rw");
      reg_wr(ADDR_CHG_EN, 16'h0000);
      reg_rd_chk(8'h7F, 16'h0000, "unmapped");
      for (int i = 0; i < 6; i++) begin
         reg_wr(8'(ADDR_IIN_HI_LIM + i), thr[i]);
         reg_rd_chk(8'(ADDR_IIN_HI_LIM + i), thr[i], "threshold");
      end
      for (int i = 0; i < 6; i++) begin
         reg_wr(ADDR_LIMIT_EN, 16'h0000);
         cae_charger_model_i.set_tel(tel_of[i], trip[i]);
         settle();
         reg_rd_chk(ADDR_LIMIT_FLAGS, 16'h0000, "limit gated");
         chk_alert(1'b1);
         reg_wr(ADDR_LIMIT_EN, 16'(1 << i));
         reg_rd_chk(ADDR_LIMIT_EN, 16'(1 << i), "limit enable");
         settle();
         reg_rd_chk(ADDR_LIMIT_FLAGS, 16'(1 << i), "limit flag");
         chk_alert(1'b0);
         cae_charger_model_i.set_tel(tel_of[i], 16'h0000);
         reg_wr(ADDR_LIMIT_EN, 16'h0000);
         settle();
         chk_alert(1'b1);
         reg_rd_chk(ADDR_LIMIT_FLAGS, 16'(1 << i), "limit kept");
         reg_wr(ADDR_LIMIT_FLAGS, 16'(1 << i));
         reg_rd_chk(ADDR_LIMIT_FLAGS, 16'h0000, "limit clear");
      end
      for (int i = 0; i < 6; i++) begin
         reg_wr(ADDR_CHG_EN, 16'h0000);
         cae_charger_model_i.pulse(i);
         settle();
         reg_rd_chk(ADDR_CHG_FLAGS, 16'h0000, "chg gated");
         reg_wr(ADDR_CHG_EN, 16'(1 << chg_bit[i]));
         cae_charger_model_i.pulse(i);
         settle();
         reg_rd_chk(ADDR_CHG_FLAGS, 16'(1 << chg_bit[i]), "chg flag");
         chk_alert(1'b0);
         reg_wr(ADDR_CHG_FLAGS, 16'(1 << chg_bit[i]));
         settle();
         chk_alert(1'b1);
         reg_rd_chk(ADDR_CHG_FLAGS, 16'h0000, "chg clear");
      end
      summarize();
   end
endmodule // cae_alert_top_test

// *** tb/cae_charger_model.sv ***
// charger side model: telemetry readings and charger state events
`timescale 1ns/1ps
module cae_charger_model (
   input  wire logic          core_clk,
   output logic signed [15:0] input_current,
   output logic signed [15:0] battery_current,
   output logic signed [15:0] die_temp,
   output logic signed [15:0] series_resistance,
   output logic signed [15:0] ntc_reading,
   output logic               detect_failed_event,
   output logic               detect_entry_event,
   output logic               absorb_start_event,
   output logic               suspended_event,
   output logic               regulated_charge_phase,
   output logic               thermal_pause_event
);
   logic [5:0] ev;

   // =====================================================
   // event lines
   assign detect_failed_event    = ev[0];
   assign detect_entry_event     = ev[1];
   assign absorb_start_event     = ev[2];
   assign suspended_event        = ev[3];
   assign regulated_charge_phase = ev[4];
   assign thermal_pause_event    = ev[5];

   initial begin
      ev                <= 6'h0;
      input_current     <= 16'h0000;
      battery_current   <= 16'h0000;
      die_temp          <= 16'h0000;
      series_resistance <= 16'h0000;
      ntc_reading       <= 16'h0000;
   end

   // =====================================================
   // stimulus tasks
   task automatic set_tel(input int idx, input logic signed [15:0] v);
      @(posedge core_clk);
      case (idx)
         0: input_current <= v;
         1: battery_current <= v;
         2: die_temp <= v;
         3: series_resistance <= v;
         default: ntc_reading <= v;
      endcase
   endtask

   task automatic pulse(input int idx);
      @(posedge core_clk);
      ev[idx] <= 1'b1;
      @(posedge core_clk);
      ev[idx] <= 1'b0;
   endtask
endmodule // cae_charger_model
